// *** rtl/udhv_map.svh ***
/*
  Timing counts and code limits for the up/down high-voltage command host.
  Assumes a 200 MHz clock; included by the host module by bare name.
*/
`ifndef UDHV_MAP_SVH
`define UDHV_MAP_SVH

`define UDHV_CLK_PERIOD_NS   5
// Setup / hold around select and direction edges, in ns
`define UDHV_SETUP_NS        500
`define UDHV_SETUP_CYC       ((`UDHV_SETUP_NS + `UDHV_CLK_PERIOD_NS - 1) / `UDHV_CLK_PERIOD_NS)
// Write cycle wait, in us (nv_write_time)
`define UDHV_NV_WRITE_US     5000
`define UDHV_NV_WRITE_CYC    (`UDHV_NV_WRITE_US * 1000 / `UDHV_CLK_PERIOD_NS)
`define UDHV_CODE_MIN        6'h00
`define UDHV_CODE_MAX        6'h3f

`endif

// *** rtl/udhv_pkg.sv ***
/*
  Types for the up/down high-voltage command host.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package udhv_pkg;

  // High-voltage commands the host can issue
  typedef enum logic [2:0] {
    UDHV_CMD_INC_UNLOCK,
    UDHV_CMD_INC_LOCK,
    UDHV_CMD_DEC_UNLOCK,
    UDHV_CMD_DEC_LOCK,
    UDHV_CMD_STORE_UNLOCK,
    UDHV_CMD_STORE_LOCK
  } udhv_cmd_t;

  // Sequencer states
  typedef enum logic [3:0] {
    UDHV_IDLE,
    UDHV_PRE,
    UDHV_HV,
    UDHV_STEP_LO,
    UDHV_STEP_HI,
    UDHV_FINAL,
    UDHV_EXIT,
    UDHV_BUSY,
    UDHV_DESEL
  } udhv_state_t;

endpackage

// *** rtl/udhv_tick.sv ***
/*
  Down-counting timer: loads a count and pulses done when it runs out.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps

module udhv_tick #(
  parameter int W = 24
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);

  logic [W-1:0] cnt_r;
  logic         run_r;

  // ==========================================================
  // Counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done  <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      run_r <= 1'b1;
      done  <= 1'b0;
    end else begin
      done <= run_r && (cnt_r <= W'(1));
      if (run_r && cnt_r <= W'(1)) run_r <= 1'b0;
      if (run_r) cnt_r <= cnt_r - W'(1);
    end
  end

endmodule

// *** rtl/udhv_host.sv ***
/*
  Host sequencer for the high-voltage commands of a two-pin up/down wiper.
  Drives select (active low), an elevated-level request and the direction pin.
  Assumes pins are outputs only and the external level shifter follows elevated_select_level.
*/
// Notes on behaviour
// R1: Direction low at high-voltage entry makes each direction rising edge decrement.
// R2: HV decrement: direction goes high before leaving high voltage; write and lock.
// R3: Device saturates at code 00; host tracks the same floor.
// R4: After leaving high voltage, host issues nothing until write time has passed.
// R5: Direction steady, select to high voltage and back: store and unlock.
// R6: Store-and-unlock: leave high voltage promptly after entering it.
// R7: Both high, enter high voltage, direction low, then leave: store and lock.
// R8: Store-and-lock: leave high voltage promptly after direction goes low.
// R9: Six distinct high-voltage commands are offered.
// R10: Code 00h is terminal B, code 3Fh terminal A.
// R11: Device saturates at code 3F; host tracks the same ceiling.
// R12: HV increment with direction high on exit: write and unlock.
// R13: Select modelled as active-low select plus separate elevated-level flag.
// R14: Write cycle is a busy interval of configurable length.
`timescale 1ns/1ps
`include "udhv_map.svh"

module udhv_host #(
  parameter int STEP_W     = 6,
  parameter int NV_WRITE_C = `UDHV_NV_WRITE_CYC,
  parameter int SETUP_C    = `UDHV_SETUP_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     cmd_valid,
  input  wire udhv_pkg::udhv_cmd_t      cmd,
  input  wire logic [STEP_W-1:0]        cmd_steps,
  output logic                          cmd_ready,
  output logic                          cmd_done,
  output logic                          sel_n,
  output logic                          elevated_select_level,
  output logic                          dir_up,
  output logic [5:0]                    code_est,
  output logic                          lock_est
);

  localparam int TW = 24;

  udhv_pkg::udhv_state_t state_r, state_nxt;
  udhv_pkg::udhv_cmd_t   cmd_r;
  logic [STEP_W-1:0]     steps_r;
  logic                  tmr_load;
  logic [TW-1:0]         tmr_count;
  logic                  tmr_done;
  logic                  waiting_r;

  // ==========================================================
  // Command decode
  wire is_inc   = (cmd_r == udhv_pkg::UDHV_CMD_INC_UNLOCK) ||
                  (cmd_r == udhv_pkg::UDHV_CMD_INC_LOCK);
  wire is_dec   = (cmd_r == udhv_pkg::UDHV_CMD_DEC_UNLOCK) ||
                  (cmd_r == udhv_pkg::UDHV_CMD_DEC_LOCK);
  wire is_store = !is_inc && !is_dec;
  // In IDLE the new command is still only on the inputs; decoding the old one would glitch
  wire udhv_pkg::udhv_cmd_t cmd_now = (state_r == udhv_pkg::UDHV_IDLE) ? cmd : cmd_r;
  // Direction level at high-voltage entry picks inc or dec [R1] [R13]
  wire dir_entry = !((cmd_now == udhv_pkg::UDHV_CMD_DEC_UNLOCK) ||
                     (cmd_now == udhv_pkg::UDHV_CMD_DEC_LOCK));
  // Direction level on exit; lock sense follows the command [R2] [R7] [R12]
  wire dir_exit = (cmd_r == udhv_pkg::UDHV_CMD_INC_UNLOCK) ||
                  (cmd_r == udhv_pkg::UDHV_CMD_DEC_LOCK) ||
                  (cmd_r == udhv_pkg::UDHV_CMD_STORE_UNLOCK);
  wire lock_new = (cmd_r == udhv_pkg::UDHV_CMD_INC_LOCK) ||
                  (cmd_r == udhv_pkg::UDHV_CMD_DEC_LOCK) ||
                  (cmd_r == udhv_pkg::UDHV_CMD_STORE_LOCK);
  wire steps_left = (steps_r != '0);
  // Saturating tracking of the device code [R3] [R11] [R10]
  wire [5:0] code_up = (code_est == `UDHV_CODE_MAX) ? code_est : code_est + 6'h01;
  wire [5:0] code_dn = (code_est == `UDHV_CODE_MIN) ? code_est : code_est - 6'h01;
  // Every timed phase except the write waits the setup count; only the write phase uses the long count [R14]
  wire tick = waiting_r && tmr_done;

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_count = TW'(SETUP_C);
    case (state_r)
      udhv_pkg::UDHV_IDLE: begin
        if (cmd_valid) begin
          state_nxt = udhv_pkg::UDHV_PRE;
          tmr_load  = 1'b1;
        end
      end
      udhv_pkg::UDHV_PRE: begin
        if (tick) begin
          state_nxt = udhv_pkg::UDHV_HV;
          tmr_load  = 1'b1;
        end
      end
      udhv_pkg::UDHV_HV: begin
        // Store commands skip stepping to leave high voltage promptly [R6] [R8]
        if (tick) begin
          state_nxt = (is_store || !steps_left) ? udhv_pkg::UDHV_FINAL
                                                : udhv_pkg::UDHV_STEP_LO;
          tmr_load  = 1'b1;
        end
      end
      udhv_pkg::UDHV_STEP_LO: begin
        if (tick) begin
          state_nxt = udhv_pkg::UDHV_STEP_HI;
          tmr_load  = 1'b1;
        end
      end
      udhv_pkg::UDHV_STEP_HI: begin
        if (tick) begin
          state_nxt = steps_left ? udhv_pkg::UDHV_STEP_LO : udhv_pkg::UDHV_FINAL;
          tmr_load  = 1'b1;
        end
      end
      udhv_pkg::UDHV_FINAL: begin
        if (tick) begin
          state_nxt = udhv_pkg::UDHV_EXIT;
          tmr_load  = 1'b1;
        end
      end
      udhv_pkg::UDHV_EXIT: begin
        // Leaving high voltage starts the device write; wait it out [R4] [R14]
        if (tick) begin
          state_nxt = udhv_pkg::UDHV_BUSY;
          tmr_load  = 1'b1;
          tmr_count = TW'(NV_WRITE_C);
        end
      end
      udhv_pkg::UDHV_BUSY: begin
        if (tick) begin
          state_nxt = udhv_pkg::UDHV_DESEL;
        end
      end
      default: begin
        state_nxt = udhv_pkg::UDHV_IDLE;
      end
    endcase
  end

  udhv_tick #(.W(TW)) u_tick (
    .clock (clock),
    .rst   (rst),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // ==========================================================
  // State, timer bookkeeping, command capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= udhv_pkg::UDHV_IDLE;
      waiting_r <= 1'b0;
      cmd_r     <= udhv_pkg::UDHV_CMD_STORE_UNLOCK;
      steps_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (tmr_load) waiting_r <= 1'b1;
      else if (tmr_done) waiting_r <= 1'b0;
      if (state_r == udhv_pkg::UDHV_IDLE && cmd_valid) begin
        cmd_r   <= cmd;
        steps_r <= cmd_steps;
      end else if (state_r == udhv_pkg::UDHV_STEP_LO && tick) begin
        steps_r <= steps_r - STEP_W'(1);
      end
    end
  end

  // ==========================================================
  // Pin drive: all from flip-flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_n                 <= 1'b1;
      elevated_select_level <= 1'b0;
      dir_up                <= 1'b1;
      cmd_ready             <= 1'b0;
      cmd_done              <= 1'b0;
    end else begin
      cmd_ready <= (state_nxt == udhv_pkg::UDHV_IDLE);
      cmd_done  <= (state_r == udhv_pkg::UDHV_DESEL);
      case (state_nxt)
        udhv_pkg::UDHV_PRE: begin
          dir_up <= dir_entry; // [R1] [R5] [R7]
        end
        udhv_pkg::UDHV_HV: begin
          elevated_select_level <= 1'b1; // [R9] [R13]
        end
        udhv_pkg::UDHV_STEP_LO: begin
          dir_up <= 1'b0;
        end
        udhv_pkg::UDHV_STEP_HI: begin
          dir_up <= 1'b1; // Rising edge moves the wiper one step
        end
        udhv_pkg::UDHV_FINAL: begin
          // Store-unlock keeps direction static [R5]
          if (!(cmd_r == udhv_pkg::UDHV_CMD_STORE_UNLOCK)) dir_up <= dir_exit;
        end
        udhv_pkg::UDHV_EXIT: begin
          elevated_select_level <= 1'b0; // [R2] [R7] [R12]
        end
        udhv_pkg::UDHV_DESEL: begin
          sel_n <= 1'b1;
        end
        default: begin
          sel_n <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Tracked wiper code and lock state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      code_est <= `UDHV_CODE_MIN;
      lock_est <= 1'b0;
    end else begin
      if (state_r == udhv_pkg::UDHV_STEP_LO && tick) begin
        code_est <= is_inc ? code_up : code_dn; // [R3] [R11]
      end
      // A zero-step lock decrement raises direction before exit, which is itself a step
      if (state_r == udhv_pkg::UDHV_HV && tick && !steps_left &&
          cmd_r == udhv_pkg::UDHV_CMD_DEC_LOCK) begin
        code_est <= code_dn; // [R2] [R3]
      end
      if (state_r == udhv_pkg::UDHV_BUSY && tick) begin
        lock_est <= lock_new; // [R14]
      end
    end
  end

endmodule

// *** sim/udhv_host_assertions.sv ***
/* Port checker for the high-voltage command host.
   Assumes a bind from the bench top file onto udhv_host. */
`timescale 1ns/1ps
module udhv_host_assertions (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       cmd_done,
  input wire logic       elevated_select_level,
  input wire logic [5:0] code_est,
  input wire logic       lock_est
);
  // ==========================================
  // Properties, all on the one clock
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  take_drop_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed high after a take");
  ready_back_a: assert property (cmd_done |-> cmd_ready)
    else $error("ready did not return after done");
  // The wait follows the exit edge, so nothing may finish right away
  write_wait_a: assert property ($fell(elevated_select_level) |-> !(cmd_done || cmd_ready) [*8])
    else $error("write wait cut short");
  code_in_hv_a: assert property ($changed(code_est) |-> elevated_select_level)
    else $error("code moved outside elevated level");
  code_step_a: assert property ($changed(code_est) |->
    (code_est - $past(code_est)) == 6'h01 || ($past(code_est) - code_est) == 6'h01)
    else $error("code moved by more than one");
  floor_hold_a: assert property ($past(code_est) == 6'h00 |-> code_est != 6'h3f)
    else $error("code wrapped below floor");
  ceil_hold_a: assert property ($past(code_est) == 6'h3f |-> code_est != 6'h00)
    else $error("code wrapped above ceiling");
  lock_time_a: assert property ($changed(lock_est) |-> ##[0:1] cmd_done)
    else $error("lock changed away from write end");
  cover property ($fell(elevated_select_level));
  cover property (cmd_done && lock_est);
  cover property (code_est == 6'h3f);
endmodule

// *** sim/udhv_dev_model.sv ***
/* Behavioural wiper device driven by the elevated flag and direction pin.
   Assumes select stays at normal high, so only the elevated flag matters. */
`timescale 1ns/1ps
module udhv_dev_model #(
  parameter int WR_NS = 80
) (
  input  wire logic       hv,
  input  wire logic       dir,
  output logic [5:0]      wiper,
  output logic            locked
);
  logic up_r;
  logic busy;
  // ==========================================
  // Code 00 is terminal B, 3f terminal A
  initial begin
    wiper = 6'h00;
    locked = 1'b0;
    busy = 1'b0;
    up_r = 1'b1;
  end
  // Direction latched at entry picks the command family
  always @(posedge hv) if (!busy) up_r = dir;
  // Rising direction edges step, saturating at both ends
  always @(posedge dir) if (hv && !busy) begin
    if (up_r && wiper != 6'h3f) wiper = wiper + 6'h01;
    else if (!up_r && wiper != 6'h00) wiper = wiper - 6'h01;
  end
  // Exit edge: lock when the direction differs from entry
  always @(negedge hv) if (!busy) begin
    locked = up_r ^ dir;
    busy = 1'b1;
    #(WR_NS); // Commands during the write are ignored
    busy = 1'b0;
  end
endmodule

// *** sim/udhv_host_tb.sv ***
/* Self-checking bench for the high-voltage command host.
   Assumes the device model and checker files are compiled first. */
`timescale 1ns/1ps
module udhv_host_tb;
  logic                clock = 1'b0;
  logic                rst = 1'b1;
  logic                cmd_valid = 1'b0;
  udhv_pkg::udhv_cmd_t cmd = udhv_pkg::UDHV_CMD_INC_UNLOCK;
  logic [5:0]          cmd_steps = 6'h00;
  logic                cmd_ready, cmd_done, sel_n, hv, dir_up, lock_est, dev_lock;
  logic [5:0]          code_est, dev_wiper;
  logic [6:0]          exp_q[$];
  logic [31:0]         rnd = 32'h1777;
  int                  error_cnt = 0, n_tests = 0, cyc = 0, ecode = 0;
  // ==========================================
  // Clock, design and partner
  always #2.5 clock = ~clock;
  udhv_host #(.NV_WRITE_C(20), .SETUP_C(3)) u_dut (.clock, .rst, .cmd_valid, .cmd,
    .cmd_steps, .cmd_ready, .cmd_done, .sel_n, .elevated_select_level(hv), .dir_up,
    .code_est, .lock_est);
  udhv_dev_model u_dev (.hv(hv), .dir(dir_up), .wiper(dev_wiper), .locked(dev_lock));
  // ==========================================
  // Shared tasks
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string nm, input logic [6:0] e, input logic [6:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Valid is held a few cycles past the take; a second take would double steps
  task automatic send(input udhv_pkg::udhv_cmd_t c, input logic [5:0] st);
    int n;
    // A zero-step lock decrement still steps once, on the direction rise before exit
    n = (c == udhv_pkg::UDHV_CMD_DEC_LOCK && st == 6'h00) ? 1 : int'(st);
    @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    cmd = c;
    cmd_steps = st;
    cmd_valid = 1'b1;
    repeat (4) @(negedge clock);
    cmd_valid = 1'b0;
    if (c < 3'd2) ecode = (ecode + n > 63) ? 63 : ecode + n;
    else if (c < 3'd4) ecode = (ecode < n) ? 0 : ecode - n;
    exp_q.push_back({c[0], 6'(ecode)});
  endtask
  // ==========================================
  // Result watcher and hang limit
  // Sampled at the falling edge, well clear of the edge that launches the outputs
  always @(negedge clock) if (cmd_done === 1'b1) begin
    check("host code and lock", exp_q[0], {lock_est, code_est});
    check("device code and lock", exp_q.pop_front(), {dev_lock, dev_wiper});
    check("select held high", 7'h01, {6'h00, sel_n});
    $display("test %0d done", n_tests / 3);
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      complete_run;
    end
  end
  // ==========================================
  // Main sequence: edges of the range first, then random commands
  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    send(udhv_pkg::UDHV_CMD_DEC_LOCK, 6'h03);
    send(udhv_pkg::UDHV_CMD_INC_UNLOCK, 6'h3f);
    send(udhv_pkg::UDHV_CMD_INC_LOCK, 6'h05);
    send(udhv_pkg::UDHV_CMD_STORE_LOCK, 6'h00);
    send(udhv_pkg::UDHV_CMD_STORE_UNLOCK, 6'h00);
    send(udhv_pkg::UDHV_CMD_DEC_UNLOCK, 6'h0a);
    send(udhv_pkg::UDHV_CMD_DEC_LOCK, 6'h00);
    repeat (24) begin
      rnd = xs(rnd);
      send(udhv_pkg::udhv_cmd_t'(3'(rnd % 6)), {1'b0, rnd[8:4]} + 6'h01);
    end
    while (exp_q.size() != 0) @(negedge clock);
    complete_run;
  end
endmodule
bind udhv_host udhv_host_assertions u_chk (.clock, .rst, .cmd_valid, .cmd_ready, .cmd_done,
  .elevated_select_level, .code_est, .lock_est);
